// ===== table_write_and_test_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module table_write_and_test_exec_test;
  import twx_pkg::*;
  logic clk_i = 0, srst_i = 1, v = 0, ntw = 0, ext = 0, n_o, z_o, busy, dis, ix;
  logic [1:0] q = 0, nz = 0;
  logic [3:0] bank = 0;
  logic [7:0] d = 0, tl, fdat, w = 0, wo;
  logic [15:0] ins = 0;
  logic [15:0] cor [4] = '{16'h000e, 16'h000f, 16'h665f, 16'h6660};
  logic [20:0] ptr = 0, po;
  logic [31:0] s = 21, r;
  logic [63:0] hold = '1, ho;
  twx_faddr_t fa;
  int error_cnt = 0, n_tests = 0, cyc = 0, nd;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) q <= srst_i ? 2'h0 : q + 2'h1;
  always @(posedge clk_i) if (++cyc == 5000) close_out(1);
  twx_mem twx_mem_i (.clk_i(clk_i), .d_i(d), .table_latch_o(tl), .fdata_o(fdat));
  twx_core twx_core_i (.clk_i(clk_i), .srst_i(srst_i), .qphase_i(q), .instr_i(ins), .instr_valid_i(v),
    .next_two_word_i(ntw), .ext_set_en_i(ext), .bank_select_register_i(bank), .table_latch_i(tl), .fdata_i(fdat),
    .table_pointer_o(po), .hold_o(ho), .wreg_o(wo), .flag_n_o(n_o), .flag_z_o(z_o), .faddr_o(fa), .busy_o(busy),
    .discard_o(dis));
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out(input int e);
    error_cnt += e;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic op(input logic [15:0] i);
    while (!(q == 2'h3 && busy === 1'b0)) @(posedge clk_i) #1;
    r = xs();
    {ntw, ext, bank, d} = {r[13:8], r[14] ? 8'h0 : r[7:0]};
    ins = i;
    v = 1;
    @(posedge clk_i) #1 v = 0;
    if (i[15:8] == 8'h0a) begin
      w ^= i[7:0];
      nz = {w[7], w == 8'h0};
      chk("xor", {w, nz}, {wo, n_o, z_o});
    end else if (i[15:2] == 14'h3) begin
      if (i[1:0] == 2'h3) ptr++;
      hold[{ptr[2:0], 3'h0} +: 8] = d;
      ptr = i[1:0] == 2'h1 ? ptr + 21'h1 : i[1:0] == 2'h2 ? ptr - 21'h1 : ptr;
      repeat (4) @(posedge clk_i);
      #1 chk("tw", {hold, ptr, nz}, {ho, po, n_o, z_o});
    end else begin
      ix = !i[8] && ext && i[7:0] <= 8'h5f;
      chk("faddr", {ix ? 4'h0 : i[8] ? bank : i[7:0] < 8'h60 ? 4'h0 : 4'hf, i[7:0], ix}, fa);
      nd = 0;
      repeat (16) @(posedge clk_i) nd += dis;
      chk("skip", d == 8'h0 ? (ntw ? 8 : 4) : 0, nd);
    end
    $display("op %h done", i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 0;
    foreach (cor[k]) op(cor[k]);
    repeat (60) begin
      r = xs();
      op(r[1] ? {8'h0a, r[15:8]} : r[0] ? {14'h3, r[3:2]} : {7'h33, r[24:16]});
    end
    close_out(0);
  end
endmodule // table_write_and_test_exec_test
`default_nettype wire

// ===== twx_core.sv
`timescale 1ns/1ps
`default_nettype none
module twx_core #(
  parameter int unsigned PTR_W = twx_pkg::TWX_PTR_W,
  parameter int unsigned HOLD_N = twx_pkg::TWX_HOLD_N
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] qphase_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic next_two_word_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] table_latch_i,
  input wire logic [7:0] fdata_i,
  output logic [PTR_W-1:0] table_pointer_o,
  output logic [HOLD_N*8-1:0] hold_o,
  output logic [7:0] wreg_o,
  output logic flag_n_o,
  output logic flag_z_o,
  output twx_pkg::twx_faddr_t faddr_o,
  output logic busy_o,
  output logic discard_o
);
  import twx_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The holding index is a fixed three-bit field of the pointer, so the
  // holding file must have exactly that many entries, and the pointer must
  // be wider than the index for the byte lane and the word address to exist.
  if (HOLD_N != (32'd1 << TWX_SEL_W) || PTR_W <= TWX_SEL_W) begin : g_bad_param
    $error("twx_core: unsupported PTR_W or HOLD_N");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // The three opcodes are told apart by prefixes of different lengths; they
  // cannot overlap, so the decode needs no priority among them.
  twx_state_t state_r;
  logic [PTR_W-1:0] tp_r;
  logic [7:0] hold_r [HOLD_N];
  logic [7:0] w_r;
  logic n_r;
  logic z_r;
  logic [1:0] mode_r;
  logic [7:0] lat_r;
  twx_faddr_t fa_r;
  logic go;
  logic is_tw;
  logic is_tst;
  logic is_xor;
  logic [1:0] tw_mode;
  logic [7:0] lit;
  logic [7:0] xor_res;
  logic tw_last;

  assign go = instr_valid_i && (state_r == TWX_IDLE) && (qphase_i == TWX_Q4);
  assign is_tw = instr_i[15:2] == TWX_TW_OPC_PFX;
  assign is_tst = instr_i[15:9] == TWX_TST_OPC_PFX;
  assign is_xor = instr_i[15:8] == TWX_XOR_OPC_PFX;
  assign tw_mode = instr_i[1:0];
  assign lit = instr_i[7:0];
  // Last quarter of the second table write cycle: holding write and post step.
  assign tw_last = (state_r == TWX_TW2) && (qphase_i == TWX_Q4);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Instructions are accepted at Q4 so each state covers one full cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= TWX_IDLE;
    end else if (qphase_i == TWX_Q4) begin
      case (state_r)
        TWX_IDLE: begin
          if (go && is_tw) begin
            state_r <= TWX_TW2;
          end else if (go && is_tst) begin
            state_r <= TWX_SKIP1;
          end
        end
        TWX_SKIP1: begin
          if (fdata_i == 8'h00 && next_two_word_i) begin
            state_r <= TWX_SKIP2;
          end else begin
            state_r <= TWX_IDLE;
          end
        end
        default: state_r <= TWX_IDLE;
      endcase
    end
  end

  // The register file answers within the cycle; the zero test is taken at Q4 of SKIP1.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      discard_o <= 1'b0;
    end else if (qphase_i == TWX_Q4) begin
      discard_o <= (state_r == TWX_SKIP1 && fdata_i == 8'h00) || (state_r == TWX_SKIP2);
    end
  end

  // ----------------------------------------------------------------
  // File address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fa_r <= '0;
    end else if (go && is_tst) begin
      if (instr_i[8]) begin
        fa_r <= '{addr: {bank_select_register_i, instr_i[7:0]}, indexed: 1'b0};
      end else if (ext_set_en_i && instr_i[7:0] <= TWX_IDX_MAX) begin
        fa_r <= '{addr: {4'h0, instr_i[7:0]}, indexed: 1'b1};
      end else if (instr_i[7:0] < TWX_ACC_SPLIT) begin
        fa_r <= '{addr: {4'h0, instr_i[7:0]}, indexed: 1'b0};
      end else begin
        fa_r <= '{addr: {TWX_ACC_HI_BANK, instr_i[7:0]}, indexed: 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Table write
  // ----------------------------------------------------------------
  // The mode is kept from the accept edge, because the instruction word has
  // moved on by the time the second cycle steps the pointer.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_r <= TWX_MODE_NONE;
    end else if (go && is_tw) begin
      mode_r <= tw_mode;
    end
  end

  // The latch byte is taken at Q2 and held to the Q4 write, so a change of
  // the latch in Q3 cannot tear the byte that lands in the holding file.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lat_r <= 8'h00;
    end else if (state_r == TWX_TW2 && qphase_i == TWX_Q2) begin
      lat_r <= table_latch_i;
    end
  end

  // Pre-increment steps at accept, so the Q4 write already uses the new
  // index; the post modes step at the same edge as the write itself.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tp_r <= '0;
    end else if (go && is_tw && tw_mode == TWX_MODE_PREINC) begin
      tp_r <= tp_r + PTR_W'(1);
    end else if (tw_last && mode_r == TWX_MODE_POSTINC) begin
      tp_r <= tp_r + PTR_W'(1);
    end else if (tw_last && mode_r == TWX_MODE_POSTDEC) begin
      tp_r <= tp_r - PTR_W'(1);
    end
  end

  // Bit 0 of the index is the byte lane: even entries low bytes, odd high.
  for (genvar g = 0; g < HOLD_N; g++) begin : g_hold
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        hold_r[g] <= TWX_HOLD_RST;
      end else if (tw_last && tp_r[TWX_SEL_W-1:0] == TWX_SEL_W'(g)) begin
        hold_r[g] <= lat_r;
      end
    end
    assign hold_o[g*8 +: 8] = hold_r[g];
  end

  // ----------------------------------------------------------------
  // Literal XOR
  // ----------------------------------------------------------------
  // Flags are touched only here, so table writes and tests leave them alone.
  assign xor_res = w_r ^ lit;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      w_r <= 8'h00;
    end else if (go && is_xor) begin
      w_r <= xor_res;
    end
  end

  // Both flags come from the same result as W, so they never lag it by a cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      n_r <= 1'b0;
      z_r <= 1'b0;
    end else if (go && is_xor) begin
      n_r <= xor_res[TWX_SIGN_BIT];
      z_r <= xor_res == 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Busy is combinational so the fetch side sees the refusal at the very
  // edge that would otherwise take the next instruction.
  assign table_pointer_o = tp_r;
  assign wreg_o = w_r;
  assign flag_n_o = n_r;
  assign flag_z_o = z_r;
  assign faddr_o = fa_r;
  assign busy_o = state_r != TWX_IDLE;
endmodule // twx_core
`default_nettype wire

// ===== twx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module twx_mem (
  input wire logic clk_i,
  input wire logic [7:0] d_i,
  output logic [7:0] table_latch_o,
  output logic [7:0] fdata_o
);
  // Storage answers one clock late, so the core never sees a byte in the cycle it is loaded.
  always_ff @(posedge clk_i) table_latch_o <= d_i;
  assign fdata_o = table_latch_o;
endmodule // twx_mem
`default_nettype wire

// ===== twx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module twx_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] qphase_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] fdata_i,
  input wire logic [20:0] table_pointer_o,
  input wire logic [7:0] wreg_o,
  input wire logic flag_n_o,
  input wire logic flag_z_o,
  input wire logic busy_o,
  input wire logic discard_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire ac = qphase_i == 2'h3 && instr_valid_i && !busy_o;
  wire xo = ac && instr_i[15:8] == 8'h0a;
  AST_XOR: assert property (xo |=> wreg_o == ($past(wreg_o) ^ $past(instr_i[7:0])))
    else $error("xor result");
  AST_NZ: assert property (xo |=> flag_n_o == wreg_o[7] && flag_z_o == (wreg_o == 8'h0))
    else $error("xor flags");
  AST_TW2: assert property (ac && instr_i[15:2] == 14'h3 |=> busy_o [*4] ##1 !busy_o)
    else $error("table write length");
  AST_PRE: assert property (ac && instr_i == 16'h000f |=> table_pointer_o == $past(table_pointer_o) + 21'h1)
    else $error("pre increment");
  AST_INC: assert property (ac && instr_i == 16'h000d |-> ##5 table_pointer_o == $past(table_pointer_o, 5) + 21'h1)
    else $error("post increment");
  AST_DEC: assert property (ac && instr_i == 16'h000e |-> ##5 table_pointer_o == $past(table_pointer_o, 5) - 21'h1)
    else $error("post decrement");
  AST_KEEP: assert property (ac && instr_i == 16'h000c |-> ##5 table_pointer_o == $past(table_pointer_o, 5))
    else $error("pointer kept");
  AST_SKIP: assert property (ac && instr_i[15:9] == 7'h33 ##4 1 |=> discard_o == ($past(fdata_i) == 8'h0))
    else $error("skip on zero");
endmodule // twx_monitor
bind twx_core twx_monitor twx_monitor_i (.clk_i(clk_i), .srst_i(srst_i), .qphase_i(qphase_i), .instr_i(instr_i),
  .instr_valid_i(instr_valid_i), .fdata_i(fdata_i), .table_pointer_o(table_pointer_o), .wreg_o(wreg_o),
  .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .busy_o(busy_o), .discard_o(discard_o));
`default_nettype wire

// ===== twx_pkg.sv
`default_nettype none
package twx_pkg;
  localparam int unsigned TWX_PTR_W = 21;
  localparam int unsigned TWX_HOLD_N = 8;
  localparam int unsigned TWX_SEL_W = 3;
  localparam logic [13:0] TWX_TW_OPC_PFX = 14'h0003;
  localparam logic [6:0] TWX_TST_OPC_PFX = 7'h33;
  localparam logic [7:0] TWX_XOR_OPC_PFX = 8'h0a;
  localparam logic [7:0] TWX_HOLD_RST = 8'hff;
  localparam int unsigned TWX_SIGN_BIT = 7;
  localparam logic [7:0] TWX_IDX_MAX = 8'h5f;
  localparam logic [7:0] TWX_ACC_SPLIT = 8'h60;
  localparam logic [3:0] TWX_ACC_HI_BANK = 4'hf;
  localparam logic [1:0] TWX_Q2 = 2'h1;
  localparam logic [1:0] TWX_Q4 = 2'h3;
  localparam logic [1:0] TWX_MODE_NONE = 2'h0;
  localparam logic [1:0] TWX_MODE_POSTINC = 2'h1;
  localparam logic [1:0] TWX_MODE_POSTDEC = 2'h2;
  localparam logic [1:0] TWX_MODE_PREINC = 2'h3;
  typedef enum {TWX_IDLE, TWX_TW2, TWX_SKIP1, TWX_SKIP2} twx_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic indexed;
  } twx_faddr_t;
endpackage
`default_nettype wire
